// File: hw/bms_master.sv
`timescale 1ns/1ns
module bms_master #(
  parameter bit STEP_EN = 1'b1,
  parameter bit FB2B_EN = 1'b1,
  parameter bit B2B_EN = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Backend request
  input wire logic req_valid,
  input wire logic req_step,
  input wire logic req_lock,
  input wire logic req_write,
  input wire logic [3:0] req_cmd,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_be,
  input wire logic [31:0] req_wdata,
  input wire logic req_ready,
  input wire logic req_last,
  input wire logic repeat_target_flag,
  input wire logic latency_timer_expired,
  input wire logic perr_pulse,
  // Backend status
  output logic phase_done,
  output logic [31:0] rd_data,
  output logic master_abort,
  output logic target_abort,
  output logic lock_owned,
  // Bus inputs
  input wire logic gnt_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic devsel_n,
  input wire logic [31:0] ad_i,
  // Bus two-way pins
  input wire logic frame_n_i,
  output logic frame_n_o,
  output logic frame_oe,
  input wire logic irdy_n_i,
  output logic irdy_n_o,
  output logic irdy_oe,
  input wire logic lock_n_i,
  output logic lock_n_o,
  output logic lock_oe,
  output logic [31:0] ad_o,
  output logic ad_oe,
  output logic [3:0] cbe_n_o,
  output logic cbe_oe,
  output logic par_o,
  output logic par_oe,
  output logic perr_n_o,
  output logic perr_oe,
  output logic req_n
);

  // Two-stage synchronisers for bus pins (active-high after inversion later)
  logic [37:0] sy1_q, sy2_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy1_q <= {6'h3f, 32'h0000_0000};
      sy2_q <= {6'h3f, 32'h0000_0000};
    end
    else
    begin
      sy1_q <= {gnt_n, trdy_n, stop_n, devsel_n, frame_n_i, irdy_n_i, ad_i};
      sy2_q <= sy1_q;
    end
  end

  // Lock pin synchroniser
  logic lk1_q, lk2_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lk1_q <= 1'b1;
      lk2_q <= 1'b1;
    end
    else
    begin
      lk1_q <= lock_n_i;
      lk2_q <= lk1_q;
    end
  end

  // Sampled bus levels, active high
  logic gnt, trdy, stop, devsel, frame, irdy, lock_a;
  logic [31:0] ad_s;
  assign gnt = !sy2_q[37];
  assign trdy = !sy2_q[36];
  assign stop = !sy2_q[35];
  assign devsel = !sy2_q[34];
  assign frame = !sy2_q[33];
  assign irdy = !sy2_q[32];
  assign ad_s = sy2_q[31:0];
  assign lock_a = !lk2_q;

  // State registers
  bms_pkg::bms_state_e st_q, st_d, prev_q;
  bms_pkg::bms_lock_e lk_q, lk_d;
  logic own_q, own_d;
  logic cyc_wr_q, cyc_wr_d;
  logic qb2b_q, qb2b_d;
  logic [2:0] tmr_q, tmr_d;
  logic sel_seen_q, sel_seen_d;
  logic select_timer_expired;
  logic go, stage, bus_idle, my_irdy, my_frame;

  assign stage = STEP_EN & req_step;
  assign go = req_valid & !stage;
  assign bus_idle = !frame & !irdy;
  assign select_timer_expired = (tmr_q == bms_pkg::DEVSEL_WIN_C) & !sel_seen_q;

  // Next-state logic for the sequencer
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      bms_pkg::BMS_IDLE:
      begin
        if (gnt & bus_idle)
          st_d = go ? bms_pkg::BMS_LAUNCH : bms_pkg::BMS_PARK;
      end
      bms_pkg::BMS_LAUNCH:
        st_d = bms_pkg::BMS_XFER;
      bms_pkg::BMS_XFER:
      begin
        if (frame | (!trdy & !stop & !select_timer_expired))
          st_d = bms_pkg::BMS_XFER;
        else if (FB2B_EN & go & gnt & trdy & !stop & cyc_wr_q
                 & (repeat_target_flag | qb2b_q))
          st_d = bms_pkg::BMS_LAUNCH;
        else if (stop | select_timer_expired)
          st_d = bms_pkg::BMS_STOPTA;
        else
          st_d = bms_pkg::BMS_RELEASE;
      end
      bms_pkg::BMS_RELEASE:
      begin
        if (!gnt)
          st_d = bms_pkg::BMS_IDLE;
        else if (go & B2B_EN)
          st_d = bms_pkg::BMS_LAUNCH;
        else if (go)
          st_d = bms_pkg::BMS_IDLE;
        else
          st_d = bms_pkg::BMS_PARK;
      end
      bms_pkg::BMS_STOPTA:
        st_d = gnt ? bms_pkg::BMS_PARK : bms_pkg::BMS_IDLE;
      bms_pkg::BMS_PARK:
      begin
        if (!gnt)
          st_d = bms_pkg::BMS_IDLE;
        else if (go)
          st_d = bms_pkg::BMS_LAUNCH;
        else
          st_d = bms_pkg::BMS_PARK;
      end
      default:
        st_d = bms_pkg::BMS_IDLE;
    endcase
  end

  // Select timer, write history and lock tracking next values
  always_comb
  begin
    tmr_d = tmr_q;
    sel_seen_d = sel_seen_q;
    cyc_wr_d = cyc_wr_q;
    if (st_q == bms_pkg::BMS_LAUNCH)
    begin
      tmr_d = 3'h0;
      sel_seen_d = 1'b0;
      cyc_wr_d = req_write;
    end
    else if (st_q == bms_pkg::BMS_XFER)
    begin
      if (tmr_q != bms_pkg::DEVSEL_WIN_C)
        tmr_d = tmr_q + 3'h1;
      if (devsel)
        sel_seen_d = 1'b1;
    end
    // Ownership taken on an idle bus, held while frame, lock or own drive active
    // Own drive counts because the synced pins lag our own frame by two clocks
    own_d = (!lock_a & bus_idle & req_valid & gnt & req_lock)
            | (own_q & (frame | lock_a | frame_oe));
    lk_d = lk_q;
    if (lk_q == bms_pkg::BMS_LK_FREE)
    begin
      if (lock_a & !own_q)
        lk_d = bms_pkg::BMS_LK_BUSY;
    end
    else if (!lock_a & !frame)
      lk_d = bms_pkg::BMS_LK_FREE;
  end

  // Sequencer and tracker registers; nothing survives an aborted cycle beyond history
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= bms_pkg::BMS_IDLE;
      prev_q <= bms_pkg::BMS_IDLE;
      lk_q <= bms_pkg::BMS_LK_FREE;
      own_q <= 1'b0;
      tmr_q <= 3'h0;
      sel_seen_q <= 1'b0;
      cyc_wr_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      prev_q <= st_q;
      lk_q <= lk_d;
      own_q <= own_d;
      tmr_q <= tmr_d;
      sel_seen_q <= sel_seen_d;
      cyc_wr_q <= cyc_wr_d;
    end
  end

  // Frame, ready, request and lock drive
  assign my_frame = (st_q == bms_pkg::BMS_LAUNCH)
                    | ((st_q == bms_pkg::BMS_XFER) & !select_timer_expired
                       & ((!req_last & (!latency_timer_expired | gnt) & !stop)
                          | !req_ready));
  assign my_irdy = (st_q == bms_pkg::BMS_XFER)
                   & (req_ready | select_timer_expired);
  assign frame_n_o = !my_frame;
  assign frame_oe = (st_q == bms_pkg::BMS_LAUNCH) | (st_q == bms_pkg::BMS_XFER);
  assign irdy_n_o = !my_irdy;
  assign irdy_oe = frame_oe | (st_q == bms_pkg::BMS_RELEASE);
  assign req_n = !(req_valid & (!req_lock | (lk_q == bms_pkg::BMS_LK_FREE))
                   & !((st_q == bms_pkg::BMS_STOPTA)
                       & (prev_q == bms_pkg::BMS_STOPTA)));
  assign lock_n_o = !(own_q & frame_oe);
  assign lock_oe = own_q & (frame_oe | frame | lock_a);
  assign lock_owned = own_q;
  assign phase_done = my_irdy & (trdy | stop);
  assign master_abort = (st_q == bms_pkg::BMS_XFER) & select_timer_expired;
  assign target_abort = (st_q == bms_pkg::BMS_XFER) & !frame & my_irdy
                        & stop & !devsel;

  // Address/data and command drive, registered against the next state
  logic [31:0] ad_q, ad_d, rd_q, rd_d;
  logic [3:0] cbe_q, cbe_d;
  logic par_q, par_oe_q, perr_q;
  always_comb
  begin
    ad_d = 32'h0000_0000;
    cbe_d = 4'h0;
    rd_d = rd_q;
    case (st_d)
      bms_pkg::BMS_LAUNCH:
      begin
        ad_d = req_addr;
        cbe_d = req_cmd;
      end
      bms_pkg::BMS_XFER:
      begin
        ad_d = req_wdata;
        cbe_d = req_be;
      end
      bms_pkg::BMS_PARK:
      begin
        if (stage & req_valid)
        begin
          ad_d = req_addr;
          cbe_d = req_cmd;
        end
      end
      default:
      begin
        ad_d = 32'h0000_0000;
        cbe_d = 4'h0;
      end
    endcase
    if ((st_q == bms_pkg::BMS_XFER) & !cyc_wr_q & my_irdy & trdy)
      rd_d = ad_s;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ad_q <= 32'h0000_0000;
      cbe_q <= 4'h0;
      rd_q <= 32'h0000_0000;
      par_q <= 1'b0;
      par_oe_q <= 1'b0;
      perr_q <= 1'b0;
    end
    else
    begin
      ad_q <= ad_d;
      cbe_q <= cbe_d;
      rd_q <= rd_d;
      par_q <= ^{ad_q, cbe_n_o};
      par_oe_q <= ad_oe;
      perr_q <= perr_pulse;
    end
  end

  assign ad_o = ad_q;
  assign cbe_n_o = cbe_q;
  assign ad_oe = (st_q == bms_pkg::BMS_LAUNCH) | (st_q == bms_pkg::BMS_PARK)
                 | ((st_q == bms_pkg::BMS_XFER) & cyc_wr_q);
  assign cbe_oe = (st_q == bms_pkg::BMS_LAUNCH) | (st_q == bms_pkg::BMS_XFER)
                  | (st_q == bms_pkg::BMS_PARK);
  assign par_o = par_q;
  assign par_oe = par_oe_q;
  assign perr_n_o = !perr_pulse;
  assign perr_oe = perr_pulse | perr_q;
  assign rd_data = rd_q;

  // Control and sticky status registers; a new event beats its clear
  logic mabt_q, mabt_d, tabt_q, tabt_d;
  logic [31:0] rdat_q, rdat_d;
  always_comb
  begin
    qb2b_d = qb2b_q;
    mabt_d = mabt_q;
    tabt_d = tabt_q;
    rdat_d = 32'h0000_0000;
    if (reg_wr & (reg_addr == bms_pkg::CTRL_OFS))
      qb2b_d = reg_wdata[bms_pkg::CTRL_QB2B_BIT];
    if (reg_wr & (reg_addr == bms_pkg::STAT_OFS))
    begin
      mabt_d = mabt_q & !reg_wdata[bms_pkg::STAT_MABT_BIT];
      tabt_d = tabt_q & !reg_wdata[bms_pkg::STAT_TABT_BIT];
    end
    if (master_abort)
      mabt_d = 1'b1;
    if (target_abort)
      tabt_d = 1'b1;
    if (reg_rd & (reg_addr == bms_pkg::CTRL_OFS))
      rdat_d[bms_pkg::CTRL_QB2B_BIT] = qb2b_q;
    if (reg_rd & (reg_addr == bms_pkg::STAT_OFS))
    begin
      rdat_d[bms_pkg::STAT_MABT_BIT] = mabt_q;
      rdat_d[bms_pkg::STAT_TABT_BIT] = tabt_q;
      rdat_d[bms_pkg::STAT_LOCK_BIT] = lk_q;
      rdat_d[bms_pkg::STAT_OWN_BIT] = own_q;
      rdat_d[bms_pkg::STAT_ST_LSB +: 3] = st_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      qb2b_q <= bms_pkg::CTRL_QB2B_RST;
      mabt_q <= 1'b0;
      tabt_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      qb2b_q <= qb2b_d;
      mabt_q <= mabt_d;
      tabt_q <= tabt_d;
      rdat_q <= rdat_d;
    end
  end

  assign reg_rdata = rdat_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_launch;
    st_q == bms_pkg::BMS_LAUNCH;
  endsequence
  sequence s_xfer_frame;
    (st_q == bms_pkg::BMS_XFER) ##0 frame_oe;
  endsequence

  idle_leave_a: assert property ((st_q == bms_pkg::BMS_IDLE) && !(gnt && bus_idle)
    |=> st_q == bms_pkg::BMS_IDLE) else $error("idle left without grant");
  park_enter_a: assert property ((st_q == bms_pkg::BMS_IDLE) && gnt && bus_idle && !go
    |=> st_q == bms_pkg::BMS_PARK) else $error("granted idle did not park");
  launch_xfer_a: assert property (s_launch |=> s_xfer_frame)
    else $error("launch not followed by transfer");
  launch_drive_a: assert property (s_launch |-> frame_oe && !frame_n_o && ad_oe && cbe_oe)
    else $error("launch does not drive bus");
  irdy_only_a: assert property (!irdy_n_o |-> st_q == bms_pkg::BMS_XFER)
    else $error("ready outside transfer");
  stop_turn_a: assert property ((st_q == bms_pkg::BMS_STOPTA)
    |=> (st_q == (($past(gnt)) ? bms_pkg::BMS_PARK : bms_pkg::BMS_IDLE)))
    else $error("stop turnaround exit wrong");
  park_grant_a: assert property ((st_q == bms_pkg::BMS_PARK) && !gnt
    |=> st_q == bms_pkg::BMS_IDLE) else $error("park held without grant");
  req_hold_a: assert property ((st_q == bms_pkg::BMS_STOPTA)
    && (prev_q == bms_pkg::BMS_STOPTA) |-> req_n) else $error("request not withheld");
  mabt_flag_a: assert property (master_abort |=> mabt_q)
    else $error("master abort not recorded");
  par_oe_a: assert property (ad_oe |=> par_oe) else $error("parity enable lag wrong");
  perr_oe_a: assert property (perr_pulse |-> perr_oe ##1 perr_oe)
    else $error("error enable too short");
  lock_free_a: assert property ((lk_q == bms_pkg::BMS_LK_BUSY) && !lock_a && !frame
    |=> lk_q == bms_pkg::BMS_LK_FREE) else $error("lock tracker stuck");

endmodule

// File: hw/bms_pkg.sv
// Functional notes
// - Idle waits for a request; leaves only when granted and bus idle.
// - Granted with no request, or staging, from idle/release goes to park drive.
// - Granted master with nothing pending parks instead of staying idle.
// - Command launch drives address and command, then always enters data transfer.
// - Staging support is optional; all transition paths remain.
// - Direct data-to-launch only after a clean write completion, same target or quick enable.
// - The quick back-to-back path may be left out.
// - Stop or timer expiry with frame released goes to stop turnaround, then park or idle.
// - Release turnaround deasserts signals before floating, then launch, park or idle.
// - Release-to-launch path may be omitted when back-to-back is unused.
// - Park drive holds while granted and not ready; launches when ready, idles on grant loss.
// - Park drives address/command or valid levels; data phase drives enables, write data.
// - Frame asserted in launch, and held in data per timer, phase and readiness.
// - Initiator ready asserted only in data transfer, when ready or timer expired.
// - Request line follows pending request, lock-gated, withheld on repeated stop turnaround.
// - Master abort when select timer expires in data transfer without target select.
// - Target abort when stop with no select while frame released and ready asserted.
// - Lock ownership taken on idle bus with locked request and grant; held while busy.
// - Lock tracker busy on foreign lock, free when frame and lock both released.
// - Parity is even over address/data and command lines; enable lags one clock.
// - Parity error line driven from one-clock pulse; enable lasts one clock longer.
// - No memory of retried or aborted transactions; backend re-requests.
// - Data phase completes when ready asserted with stop or target ready.
package bms_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    BMS_IDLE = 3'b000,
    BMS_LAUNCH = 3'b001,
    BMS_XFER = 3'b010,
    BMS_RELEASE = 3'b011,
    BMS_STOPTA = 3'b100,
    BMS_PARK = 3'b101
  } bms_state_e;

  // Lock tracker states
  typedef enum logic {
    BMS_LK_FREE = 1'b0,
    BMS_LK_BUSY = 1'b1
  } bms_lock_e;

  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  // Control fields
  localparam int CTRL_QB2B_BIT = 0;
  localparam logic CTRL_QB2B_RST = 1'b0;
  // Status fields
  localparam int STAT_MABT_BIT = 0;
  localparam int STAT_TABT_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_OWN_BIT = 3;
  localparam int STAT_ST_LSB = 4;
  // Select timer window in clocks after launch
  localparam int DEVSEL_WIN = 5;
  localparam logic [2:0] DEVSEL_WIN_C = 3'(DEVSEL_WIN);

endpackage

// File: verif/bms_bus_model.sv
`timescale 1ns/1ns
module bms_bus_model #(
  parameter logic [31:0] RDATA = 32'h5a5a_0f0f
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Scenario controls
  input wire logic [1:0] mode,
  input wire logic park,
  input wire logic ext_lock_n,
  // Master drive
  input wire logic req_n,
  input wire logic frame_n_o,
  input wire logic frame_oe,
  input wire logic irdy_n_o,
  input wire logic irdy_oe,
  input wire logic lock_n_o,
  input wire logic lock_oe,
  // Resolved bus
  output logic gnt_n,
  output logic trdy_n,
  output logic stop_n,
  output logic devsel_n,
  output logic [31:0] ad_i,
  output logic frame_w,
  output logic irdy_w,
  output logic lock_w
);
  logic act_q;
  logic sel;
  logic [31:0] pat_q;
  // Pulled-up lines; a third agent may hold lock
  assign frame_w = frame_oe ? frame_n_o : 1'h1;
  assign irdy_w = irdy_oe ? irdy_n_o : 1'h1;
  assign lock_w = (lock_oe ? lock_n_o : 1'h1) & ext_lock_n;
  // Arbiter grants on request or to park
  assign gnt_n = !(park || !req_n);
  // Fast decode; mode 1 stays silent, mode 2 aborts
  assign sel = act_q || !frame_w;
  assign devsel_n = !(sel && mode == 2'h0);
  assign trdy_n = !(sel && mode == 2'h0);
  assign stop_n = !(sel && mode == 2'h2);
  assign ad_i = sel ? RDATA : pat_q;
  // Claim until the phase completes, then release
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_q <= 1'h0;
      pat_q <= 32'h0;
    end
    else
    begin
      act_q <= !frame_w || (act_q && !irdy_w && trdy_n && stop_n);
      pat_q <= ~pat_q;
    end
  end
endmodule

// File: verif/bms_master_tb.sv
`timescale 1ns/1ns
module bms_master_tb;
  // Stimulus
  logic mclk = 1'h0, rst_n = 1'h0, park = 1'h0, ext_lock_n = 1'h1;
  logic [1:0] mode = 2'h0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_data, ad_o, ad_i, d;
  logic reg_wr = 1'h0, reg_rd = 1'h0, req_valid = 1'h0, req_step = 1'h0;
  logic req_lock = 1'h0, req_write = 1'h0, req_ready = 1'h1, req_last = 1'h1;
  logic repeat_target_flag = 1'h0, latency_timer_expired = 1'h0, perr_pulse = 1'h0;
  logic [3:0] req_cmd = 4'h7, req_be = 4'h2, cbe_n_o;
  logic [31:0] req_addr = 32'h1000_0040, req_wdata = 32'hc3a5_9601;
  // Observed
  logic phase_done, master_abort, target_abort, lock_owned, req_n, gnt_n, trdy_n;
  logic stop_n, devsel_n, frame_w, irdy_w, lock_w, frame_n_o, frame_oe, irdy_n_o;
  logic irdy_oe, lock_n_o, lock_oe, ad_oe, cbe_oe, par_o, par_oe, perr_n_o, perr_oe;
  int err_total = 0, checks = 0, cyc = 0;
  logic ma_seen = 1'h0, ta_seen = 1'h0, own_seen = 1'h0;
  localparam logic [31:0] RDATA = 32'h5a5a_0f0f;

  bms_master dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .req_valid, .req_step, .req_lock, .req_write, .req_cmd, .req_addr, .req_be, .req_wdata,
    .req_ready, .req_last, .repeat_target_flag, .latency_timer_expired, .perr_pulse,
    .phase_done, .rd_data, .master_abort, .target_abort, .lock_owned, .gnt_n, .trdy_n,
    .stop_n, .devsel_n, .ad_i, .frame_n_i(frame_w), .frame_n_o, .frame_oe,
    .irdy_n_i(irdy_w), .irdy_n_o, .irdy_oe, .lock_n_i(lock_w), .lock_n_o, .lock_oe,
    .ad_o, .ad_oe, .cbe_n_o, .cbe_oe, .par_o, .par_oe, .perr_n_o, .perr_oe, .req_n);
  bms_bus_model #(.RDATA(RDATA)) bus (.mclk, .rst_n, .mode, .park, .ext_lock_n, .req_n,
    .frame_n_o, .frame_oe, .irdy_n_o, .irdy_oe, .lock_n_o, .lock_oe, .gnt_n, .trdy_n,
    .stop_n, .devsel_n, .ad_i, .frame_w, .irdy_w, .lock_w);

  // Clock
  always #50 mclk = ~mclk;
  // Hang guard and pulse monitors
  always @(posedge mclk)
  begin
    cyc++;
    if (master_abort === 1'h1) ma_seen <= 1'h1;
    if (target_abort === 1'h1) ta_seen <= 1'h1;
    if (lock_owned === 1'h1 && lock_oe === 1'h1 && lock_n_o === 1'h0) own_seen <= 1'h1;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim;
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Register port cycles
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(negedge mclk);
    v = reg_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask

  // Poll the state code until it matches, bounded
  task automatic wait_st(input bms_pkg::bms_state_e s, input string n);
    for (int i = 0; i < 40; i++)
    begin
      rd(bms_pkg::STAT_OFS, d);
      if (d[bms_pkg::STAT_ST_LSB +: 3] === s) break;
    end
    chk(n, 32'(d[bms_pkg::STAT_ST_LSB +: 3]), 32'(s));
  endtask

  // One transaction; mode 0 normal, 1 no claim, 2 target abort
  task automatic xfer(input logic w, input logic [1:0] m, input bms_pkg::bms_state_e fin);
    logic p;
    logic oe;
    @(posedge mclk);
    mode <= m;
    req_write <= w;
    req_valid <= 1'h1;
    ma_seen = 1'h0;
    ta_seen = 1'h0;
    for (int i = 0; i < 60 && !(frame_oe === 1'h1 && frame_n_o === 1'h0); i++)
      @(negedge mclk);
    chk("launch address", ad_o, req_addr);
    chk("launch command", {cbe_oe, ad_oe, cbe_n_o}, {2'h3, req_cmd});
    p = ^{ad_o, cbe_n_o};
    oe = ad_oe;
    @(posedge mclk);
    req_valid <= 1'h0;
    @(negedge mclk);
    chk("parity", {par_oe, par_o}, {oe, p});
    if (m == 2'h0)
    begin
      for (int i = 0; i < 20 && !(irdy_oe === 1'h1 && irdy_n_o === 1'h0); i++)
        @(negedge mclk);
      chk("data drive", {ad_oe, cbe_oe, cbe_n_o}, {w, 1'h1, req_be});
      if (w) chk("write data", ad_o, req_wdata);
      for (int i = 0; i < 20 && phase_done !== 1'h1; i++)
        @(negedge mclk);
      chk("phase done", phase_done, 1);
      @(negedge mclk);
      if (!w) chk("read data", rd_data, RDATA);
    end
    wait_st(fin, "end state");
    rd(bms_pkg::STAT_OFS, d);
    chk("abort flags", d[1:0], {30'h0, m});
    chk("abort pulses", {ta_seen, ma_seen}, {30'h0, m});
    wr(bms_pkg::STAT_OFS, 32'h3);
    rd(bms_pkg::STAT_OFS, d);
    chk("flags cleared", d[1:0], 0);
    @(posedge mclk);
    mode <= 2'h0;
    $display("done: transfer w=%0d mode=%0d", w, m);
  endtask

  task automatic t_regs;
    wait_st(bms_pkg::BMS_IDLE, "idle after reset");
    chk("request idle", req_n, 1);
    rd(bms_pkg::CTRL_OFS, d);
    chk("ctrl reset", d, 32'(bms_pkg::CTRL_QB2B_RST));
    wr(bms_pkg::CTRL_OFS, 32'h1);
    rd(bms_pkg::CTRL_OFS, d);
    chk("ctrl write", d, 1);
    rd(8'h08, d);
    chk("unmapped", d, 0);
    wr(bms_pkg::CTRL_OFS, 32'h0);
    $display("done: registers");
  endtask

  // Quick back-to-back: a write with a request still pending relaunches at once
  task automatic t_b2b;
    wr(bms_pkg::CTRL_OFS, 32'h1);
    @(posedge mclk);
    req_write <= 1'h1;
    req_valid <= 1'h1;
    for (int i = 0; i < 60 && !(frame_oe === 1'h1 && frame_n_o === 1'h0); i++)
      @(negedge mclk);
    repeat (4) @(negedge mclk);
    chk("quick launch", {frame_oe, frame_n_o}, 2'h2);
    chk("quick address", ad_o, req_addr);
    @(posedge mclk);
    req_valid <= 1'h0;
    wait_st(bms_pkg::BMS_IDLE, "quick end");
    wr(bms_pkg::CTRL_OFS, 32'h0);
    $display("done: quick back-to-back");
  endtask

  task automatic t_park;
    @(posedge mclk);
    park <= 1'h1;
    wait_st(bms_pkg::BMS_PARK, "park no request");
    chk("park drive", {ad_oe, cbe_oe, irdy_oe, frame_oe}, 4'hc);
    @(posedge mclk);
    req_step <= 1'h1;
    req_valid <= 1'h1;
    repeat (8) @(posedge mclk);
    wait_st(bms_pkg::BMS_PARK, "park staging");
    chk("staged address", ad_o, req_addr);
    chk("staged command", cbe_n_o, req_cmd);
    @(posedge mclk);
    req_step <= 1'h0;
    req_valid <= 1'h0;
    xfer(1'h1, 2'h0, bms_pkg::BMS_PARK);
    @(posedge mclk);
    park <= 1'h0;
    wait_st(bms_pkg::BMS_IDLE, "grant removed");
    $display("done: park");
  endtask

  task automatic t_lock;
    @(posedge mclk);
    ext_lock_n <= 1'h0;
    repeat (4) @(posedge mclk);
    req_lock <= 1'h1;
    req_valid <= 1'h1;
    repeat (6) @(posedge mclk);
    rd(bms_pkg::STAT_OFS, d);
    chk("lock busy", d[bms_pkg::STAT_LOCK_BIT], 1);
    chk("request withheld", req_n, 1);
    @(posedge mclk);
    req_valid <= 1'h0;
    ext_lock_n <= 1'h1;
    repeat (6) @(posedge mclk);
    rd(bms_pkg::STAT_OFS, d);
    chk("lock free", d[bms_pkg::STAT_LOCK_BIT], 0);
    own_seen = 1'h0;
    xfer(1'h1, 2'h0, bms_pkg::BMS_IDLE);
    chk("lock owned", own_seen, 1);
    rd(bms_pkg::STAT_OFS, d);
    chk("own lock not busy", d[bms_pkg::STAT_LOCK_BIT], 0);
    @(posedge mclk);
    req_lock <= 1'h0;
    $display("done: lock");
  endtask

  task automatic t_perr;
    @(posedge mclk);
    perr_pulse <= 1'h1;
    @(negedge mclk);
    chk("perr pulse", {perr_oe, perr_n_o}, 2'h2);
    @(posedge mclk);
    perr_pulse <= 1'h0;
    @(negedge mclk);
    chk("perr tail", {perr_oe, perr_n_o}, 2'h3);
    @(negedge mclk);
    chk("perr off", perr_oe, 0);
    $display("done: parity error");
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    t_regs;
    xfer(1'h1, 2'h0, bms_pkg::BMS_IDLE);
    xfer(1'h0, 2'h0, bms_pkg::BMS_IDLE);
    t_b2b;
    xfer(1'h1, 2'h1, bms_pkg::BMS_IDLE);
    xfer(1'h0, 2'h2, bms_pkg::BMS_IDLE);
    t_park;
    t_lock;
    t_perr;
    end_sim;
  end
endmodule
